// file: verilog/ltr_pkg.sv
// Shared constants and types of the region latency, trigger and readout unit.
package ltr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_MEM = 8;
  localparam int unsigned IDX_W   = 3;
  localparam int unsigned STAMP_W = 9;
  localparam int unsigned NUM_PIX = 4;
  localparam int unsigned TOT_W   = 4;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  // Largest latency a 9-bit stamp can resolve, in bunch crossings.
  localparam logic [STAMP_W-1:0] MAX_LATENCY_BX = 9'h1ff;
  // Pulse-width code that marks a pixel without a hit.
  localparam logic [TOT_W-1:0]   TOT_NO_HIT     = 4'hf;
  localparam logic [STAMP_W-1:0] STAMP_RESET    = 9'h000;
  localparam logic [NUM_MEM-1:0] FREE_RESET     = 8'hff;
  localparam logic [IDX_W-1:0]   IDX_RESET      = 3'h0;

  // ----------------------------------------------------------------
  // Memory cell state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LTR_IDLE      = 2'b00,
    LTR_TRIGGERED = 2'b01,
    LTR_READOUT   = 2'b10,
    LTR_CLEAR     = 2'b11
  } ltr_state_t;

endpackage : ltr_pkg

// file: verilog/ltr_unit.sv
// Latency, trigger and readout unit shared by the four pixels of one region.
`timescale 1ns/1ns

module ltr_unit
(
  input  wire logic                                    CLK_SYS_I,
  input  wire logic                                    RST_I,
  input  wire logic [ltr_pkg::NUM_PIX-1:0]             HIT_LEADING_EDGE_I,
  input  wire logic [ltr_pkg::STAMP_W-1:0]             CROSSING_COUNTER_I,
  input  wire logic [ltr_pkg::STAMP_W-1:0]             DELAYED_CROSSING_REQUEST_I,
  input  wire logic                                    TRIGGER_I,
  input  wire logic [ltr_pkg::STAMP_W-1:0]             TRIGGER_ID_I,
  input  wire logic [ltr_pkg::STAMP_W-1:0]             TRIGGER_ID_REQUEST_I,
  input  wire logic                                    TWO_LEVEL_I,
  input  wire logic                                    TRUNCATE_I,
  input  wire logic                                    CLEAR_I,
  input  wire logic                                    TOKEN_I,
  input  wire logic [ltr_pkg::NUM_PIX*ltr_pkg::TOT_W-1:0] TOT_I,
  output logic      [ltr_pkg::IDX_W-1:0]               WR_INDEX_O,
  output logic                                         WR_VALID_O,
  output logic      [ltr_pkg::IDX_W-1:0]               RD_INDEX_O,
  output logic      [ltr_pkg::NUM_PIX*ltr_pkg::TOT_W-1:0] TOT_O,
  output logic                                         TOT_VALID_O,
  output logic                                         TOKEN_O,
  output logic      [ltr_pkg::NUM_MEM-1:0]             SLOT_FREE_O,
  output logic                                         HIT_DROPPED_O
);
  import ltr_pkg::*;

  // ----------------------------------------------------------------
  // Memory array and combinational decisions
  // ----------------------------------------------------------------
  // Nine bits cover latencies up to 511 crossings.
  logic       [STAMP_W-1:0] stamp [NUM_MEM];
  // Two-bit cell state: idle, triggered, readout, clear.
  ltr_state_t               state [NUM_MEM];
  logic       [NUM_MEM-1:0] free_mem;
  logic       [NUM_MEM-1:0] next_free;
  logic       [NUM_MEM-1:0] expire;
  logic       [NUM_MEM-1:0] id_match;
  logic       [IDX_W-1:0]   next_wr_index;
  logic                     next_wr_valid;
  logic       [IDX_W-1:0]   rd_sel;
  logic                     reading;
  logic                     do_write;
  logic                     rd_go;

  // Any pixel edge counts; busy pixels do not gate others.
  assign do_write = (|HIT_LEADING_EDGE_I) && WR_VALID_O;

  always_comb
  begin
    reading  = 1'b0;
    expire   = '0;
    id_match = '0;
    rd_sel   = IDX_RESET;
    for (int i = NUM_MEM - 1; i >= 0; i--)
    begin
      // Stamp compare against the delayed request.
      expire[i]   = !free_mem[i] && (state[i] == LTR_IDLE) && (stamp[i] == DELAYED_CROSSING_REQUEST_I);
      // Same comparator now checks the identifier request.
      id_match[i] = !free_mem[i] && (state[i] == LTR_TRIGGERED) && (stamp[i] == TRIGGER_ID_REQUEST_I);
      if (state[i] == LTR_READOUT)
      begin
        reading = 1'b1;
      end
      if (id_match[i])
      begin
        rd_sel = i[IDX_W-1:0];
      end
    end
  end

  // Only one cell reads at a time, and only while the token is here.
  assign rd_go = (|id_match) && TOKEN_I && !reading;

  always_comb
  begin
    next_wr_index = IDX_RESET;
    next_wr_valid = 1'b0;
    for (int i = 0; i < NUM_MEM; i++)
    begin
      next_free[i] = free_mem[i] && !(do_write && (WR_INDEX_O == i[IDX_W-1:0]));
      // No trigger at expiry frees the memory and its slots.
      if (expire[i] && !TRIGGER_I)
      begin
        next_free[i] = 1'b1;
      end
      if ((state[i] == LTR_READOUT) || ((state[i] == LTR_CLEAR) && CLEAR_I))
      begin
        next_free[i] = 1'b1;
      end
    end
    // The index is chosen from the post-write view so back-to-back edges never collide.
    for (int i = NUM_MEM - 1; i >= 0; i--)
    begin
      if (next_free[i])
      begin
        next_wr_index = i[IDX_W-1:0];
        next_wr_valid = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory cells
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      free_mem <= FREE_RESET;
      for (int i = 0; i < NUM_MEM; i++)
      begin
        stamp[i] <= STAMP_RESET;
        state[i] <= LTR_IDLE;
      end
    end
    else
    begin
      free_mem <= next_free;
      for (int i = 0; i < NUM_MEM; i++)
      begin
        unique case (state[i])
          LTR_IDLE:
          begin
            // Fresh cell takes the current crossing.
            if (do_write && (WR_INDEX_O == i[IDX_W-1:0]))
            begin
              stamp[i] <= CROSSING_COUNTER_I;
            end
            // Trigger at expiry labels the hits.
            else if (expire[i] && TRIGGER_I)
            begin
              stamp[i] <= TRIGGER_ID_I;
              // Clear state only for two-level or truncation.
              state[i] <= (TWO_LEVEL_I || TRUNCATE_I) ? LTR_CLEAR : LTR_TRIGGERED;
            end
          end
          LTR_TRIGGERED:
          begin
            // Lowest matching cell takes the readout.
            if (rd_go && (rd_sel == i[IDX_W-1:0]))
            begin
              state[i] <= LTR_READOUT;
            end
          end
          LTR_READOUT:
          begin
            state[i] <= LTR_IDLE;
          end
          LTR_CLEAR:
          begin
            // Two-level operation is only partly supported: a clear simply discards the event.
            if (CLEAR_I)
            begin
              state[i] <= LTR_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Slot indices and drop flag
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      WR_INDEX_O    <= IDX_RESET;
      WR_VALID_O    <= 1'b1;
      HIT_DROPPED_O <= 1'b0;
      SLOT_FREE_O   <= FREE_RESET;
    end
    else
    begin
      WR_INDEX_O    <= next_wr_index;
      WR_VALID_O    <= next_wr_valid;
      HIT_DROPPED_O <= (|HIT_LEADING_EDGE_I) && !WR_VALID_O;
      SLOT_FREE_O   <= next_free;
    end
  end

  // ----------------------------------------------------------------
  // Readout and token
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      RD_INDEX_O  <= IDX_RESET;
      TOT_O       <= {NUM_PIX{TOT_NO_HIT}};
      TOT_VALID_O <= 1'b0;
      TOKEN_O     <= 1'b0;
    end
    else
    begin
      // Pixels present the selected slot one cycle later.
      if (rd_go)
      begin
        RD_INDEX_O <= rd_sel;
      end
      // Unhit pixels show the all-ones code in the data.
      TOT_VALID_O <= reading;
      if (reading)
      begin
        TOT_O <= TOT_I;
      end
      // Token moves on unless this region holds it.
      TOKEN_O <= TOKEN_I && !rd_go && !reading;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_one_write: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    $countones(free_mem & ~next_free) <= 1)
    else $error("More than one memory taken in a crossing.");

  a_write_stamp: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    do_write |=> (!free_mem[$past(WR_INDEX_O)] && (stamp[$past(WR_INDEX_O)] == $past(CROSSING_COUNTER_I))))
    else $error("Leading edge did not store the crossing counter.");

  a_wr_free: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    WR_VALID_O |-> free_mem[WR_INDEX_O])
    else $error("Write index points at an occupied memory.");

  a_drop_full: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    ((|HIT_LEADING_EDGE_I) && !WR_VALID_O) |=> (HIT_DROPPED_O && (($past(free_mem) & ~free_mem) == '0)))
    else $error("Edge on full region was not dropped.");

  a_token_pass: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (TOKEN_I && !rd_go && !reading) |=> TOKEN_O)
    else $error("Read token not passed on.");

  for (genvar k = 0; k < NUM_MEM; k++)
  begin : g_chk
    a_release_free: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      (expire[k] && !TRIGGER_I) |=> (free_mem[k] && SLOT_FREE_O[k] && (state[k] == LTR_IDLE)))
      else $error("Expired memory without trigger not released.");

    a_trig_store: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      (expire[k] && TRIGGER_I && !TWO_LEVEL_I && !TRUNCATE_I)
        |=> (!free_mem[k] && (state[k] == LTR_TRIGGERED) && (stamp[k] == $past(TRIGGER_ID_I))))
      else $error("Triggered memory did not store the identifier.");

    a_readout_hold: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      (state[k] == LTR_READOUT) |-> (!TOKEN_O && (RD_INDEX_O == k) ##1 (TOT_VALID_O && free_mem[k])))
      else $error("Readout did not hold the token and present data.");
  end

endmodule // ltr_unit

// file: test/ltr_pixel_model.sv
// Far-side model: pixel slot storage and Gray crossing counters.
`timescale 1ns/1ns
module ltr_pixel_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  hit_i,
  input  wire logic        wr_valid_i,
  input  wire logic [2:0]  wr_index_i,
  input  wire logic [2:0]  rd_index_i,
  input  wire logic [15:0] tot_rand_i,
  input  wire logic [8:0]  latency_i,
  output logic      [8:0]  crossing_o,
  output logic      [8:0]  delayed_o,
  output logic      [15:0] tot_o
);
  import ltr_pkg::*;
  logic [8:0]  count;
  logic [8:0]  lag;
  logic [15:0] slot [8];
  assign lag = count - latency_i;
  assign crossing_o = count ^ (count >> 1);
  assign delayed_o  = lag ^ (lag >> 1);
  assign tot_o = slot[rd_index_i];
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      count <= 9'h000;
    else
      count <= count + 9'h001;
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      slot <= '{default: 16'hffff};
    else if ((|hit_i) && wr_valid_i)
      for (int p = 0; p < 4; p++)
        slot[wr_index_i][4*p+:4] <= hit_i[p] ? tot_rand_i[4*p+:4] : TOT_NO_HIT;
  end
endmodule // ltr_pixel_model

// file: test/ltr_unit_tb.sv
// Self-checking bench of the region latency, trigger and readout unit.
`timescale 1ns/1ns
module ltr_unit_tb;
  import ltr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, trig = 1'b0, two = 1'b0, trunc = 1'b0, clr = 1'b0, tok = 1'b0;
  logic [3:0]  hit = 4'h0;
  logic [8:0]  tid = 9'h000, req = 9'h000, lat = 9'd20, cg, dg;
  logic [15:0] trand = 16'h0000, tin, tout, etot [8];
  logic [2:0]  wi, ri;
  logic [7:0]  free, efree;
  logic        wv, tv, to, drop, seen;
  logic [31:0] seed = 32'hb503;
  int checked = 0, failures = 0, cycles = 0;
  ltr_unit u_ltr_unit (.CLK_SYS_I(clk), .RST_I(rst), .HIT_LEADING_EDGE_I(hit), .CROSSING_COUNTER_I(cg),
    .DELAYED_CROSSING_REQUEST_I(dg), .TRIGGER_I(trig), .TRIGGER_ID_I(tid), .TRIGGER_ID_REQUEST_I(req),
    .TWO_LEVEL_I(two), .TRUNCATE_I(trunc), .CLEAR_I(clr), .TOKEN_I(tok), .TOT_I(tin), .WR_INDEX_O(wi),
    .WR_VALID_O(wv), .RD_INDEX_O(ri), .TOT_O(tout), .TOT_VALID_O(tv), .TOKEN_O(to), .SLOT_FREE_O(free),
    .HIT_DROPPED_O(drop));
  ltr_pixel_model u_ltr_pixel_model (.clk_i(clk), .rst_i(rst), .hit_i(hit), .wr_valid_i(wv),
    .wr_index_i(wi), .rd_index_i(ri), .tot_rand_i(trand), .latency_i(lat), .crossing_o(cg),
    .delayed_o(dg), .tot_o(tin));
  always #50 clk = ~clk;
  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      failures++;
      test_done();
    end
  end
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Drives one leading-edge cycle; the model takes the lowest free memory.
  task automatic pulse_hit(input logic [3:0] m);
    @(negedge clk);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    trand = seed[15:0];
    tid = seed[24:16];
    hit = m;
    for (int k = 7; k >= 0; k--)
      if (efree[k])
        etot[k] = trand | {{4{~m[3]}}, {4{~m[2]}}, {4{~m[1]}}, {4{~m[0]}}};
    for (int k = 0; k < 8; k++)
      if (efree[k])
      begin
        efree[k] = 1'b0;
        break;
      end
    @(negedge clk);
    hit = 4'h0;
  endtask
  initial
  begin
    efree = 8'hff;
    cyc(2);
    rst = 1'b0;
    check(16'(free), 16'hff);
    check(tout, 16'hffff);
    check(16'(wv), 16'h1);
    pulse_hit(4'hf);
    cyc(1);
    check(16'(free), 16'(efree));
    check(16'(wi), 16'h1);
    cyc(24);
    efree = 8'hff;
    check(16'(free), 16'(efree));
    for (int i = 0; i < 8; i++)
      pulse_hit(4'(1 << (i % 4)));
    check(16'(free), 16'h00);
    check(16'(wv), 16'h0);
    pulse_hit(4'h1);
    seen = 1'b0;
    repeat (3)
    begin
      seen = seen | (drop === 1'b1);
      @(negedge clk);
    end
    check(16'(seen), 16'h1);
    cyc(24);
    efree = 8'hff;
    check(16'(free), 16'(efree));
    trig = 1'b1;
    pulse_hit(4'h5);
    cyc(24);
    trig = 1'b0;
    check(16'(free), 16'(efree));
    req = ~tid;
    tok = 1'b1;
    cyc(3);
    check(16'(to), 16'h1);
    req = tid;
    seen = 1'b0;
    for (int w = 0; w < 6 && tv !== 1'b1; w++)
    begin
      seen = seen | (to === 1'b0);
      @(negedge clk);
    end
    check(16'(seen), 16'h1);
    check(tout, etot[0]);
    check(16'(ri), 16'h0);
    cyc(2);
    check(16'(free), 16'hff);
    efree = 8'hff;
    for (int md = 0; md < 2; md++)
    begin
      two = (md == 0);
      trunc = (md == 1);
      trig = 1'b1;
      pulse_hit(4'h2);
      cyc(24);
      trig = 1'b0;
      req = tid;
      cyc(4);
      check(16'(free), 16'hfe);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(2);
      efree = 8'hff;
      check(16'(free), 16'(efree));
    end
    test_done();
  end
endmodule // ltr_unit_tb
